/* sfrb_consts.svh */
`ifndef SFRB_CONSTS_SVH
`define SFRB_CONSTS_SVH

// ==========================================
// Register addresses in the function register space
`define SFRB_ADDR_STACK_TOP      8'h81
`define SFRB_ADDR_DATA_POINTER_PAIR_LOW       8'h82
`define SFRB_ADDR_DATA_POINTER_PAIR_HIGH      8'h83
`define SFRB_ADDR_T0_LOW         8'h8a
`define SFRB_ADDR_T1_LOW         8'h8b
`define SFRB_ADDR_T0_HIGH        8'h8c
`define SFRB_ADDR_T1_HIGH        8'h8d
`define SFRB_ADDR_SERIAL_BUF     8'h99
`define SFRB_ADDR_EXT_CTRL       8'hc1
`define SFRB_ADDR_CAPT_LOW       8'hca
`define SFRB_ADDR_CAPT_HIGH      8'hcb
`define SFRB_ADDR_T2_LOW         8'hcc
`define SFRB_ADDR_T2_HIGH        8'hcd
`define SFRB_ADDR_ACCUM          8'he0
`define SFRB_ADDR_AUX_MUL        8'hf0

// ==========================================
// Reset values
`define SFRB_RST_STACK_TOP       8'h07
`define SFRB_RST_BYTE            8'h00
`define SFRB_RST_WORD            16'h0000
`define SFRB_RST_EXT_CTRL        8'h00

// ==========================================
// Field positions and count limit
`define SFRB_EXT_ANY_EDGE_BIT    0
`define SFRB_COUNT_MAX           16'hffff

`endif

/* sfrb_pkg.sv */
`default_nettype none
package sfrb_pkg;

	// ==========================================
	// Timer 2 operating mode
	typedef enum logic [1:0]
	{
		SFRB_T2_TIMER   = 2'b00,
		SFRB_T2_CAPTURE = 2'b01,
		SFRB_T2_RELOAD  = 2'b10
	} sfrb_t2_mode_t;

	// ==========================================
	// Control strobes of one count pair
	typedef struct packed
	{
		logic wr_lo;
		logic wr_hi;
		logic inc;
	} sfrb_cnt_ctl_t;

endpackage : sfrb_pkg
`default_nettype wire

/* sfrb_count_pair.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sfrb_consts.svh"

module sfrb_count_pair
(
	input  wire logic                  sys_clk_i,
	input  wire logic                  rst_n_i,
	input  wire sfrb_pkg::sfrb_cnt_ctl_t ctl_i,
	input  wire logic [7:0]            wdata_i,
	input  wire logic                  reload_en_i,
	input  wire logic [15:0]           reload_val_i,
	output logic      [15:0]           count_o,
	output logic                       ovf_o
);

	logic [15:0] count_r;
	logic [15:0] count_nxt;
	logic        ovf_r;
	wire         wrap_w;
	wire         any_wr_w;

	// ==========================================
	// Count datapath
	assign wrap_w   = ctl_i.inc && (count_r == `SFRB_COUNT_MAX);
	assign any_wr_w = ctl_i.wr_lo || ctl_i.wr_hi;

	// Software writes win over counting in the same cycle
	assign count_nxt = ctl_i.wr_lo ? {count_r[15:8], wdata_i} :
	                   ctl_i.wr_hi ? {wdata_i, count_r[7:0]} :
	                   (wrap_w && reload_en_i) ? reload_val_i :
	                   ctl_i.inc ? count_r + 16'h0001 :
	                   count_r;

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			count_r <= `SFRB_RST_WORD;
			ovf_r   <= 1'b0;
		end
		else
		begin
			count_r <= count_nxt;
			ovf_r   <= wrap_w && !any_wr_w;
		end
	end

	assign count_o = count_r;
	assign ovf_o   = ovf_r;

endmodule : sfrb_count_pair
`default_nettype wire

/* sfrb_bank.sv */
// Contract
// - Stack top pointer is an eight bit register.
// - Push and call increment the stack pointer before the data is stored.
// - Reset loads the stack pointer with 07h, first push lands at 08h.
// - Data pointer pair is high byte above low byte.
// - Data pointer pair reachable as one word or two independent bytes.
// - Serial buffer address is backed by separate transmit and receive registers.
// - Writing the serial buffer loads transmit data and starts transmission.
// - Reading the serial buffer returns received data, never transmit data.
// - Timers 0, 1 and 2 each count in a sixteen bit pair.
// - Capture mode copies timer 2 count into capture pair on trigger transition.
// - Reload mode reloads timer 2 from the capture pair on overflow.
// - Auxiliary multiply register holds multiply/divide operands and results, else scratch.
// - New control bits reset to zero and are active at one.
`timescale 1ns/1ps
`default_nettype none
`include "sfrb_consts.svh"

module sfrb_bank
(
	input  wire logic                    sys_clk_i,
	input  wire logic                    nrst_i,
	input  wire logic [7:0]              bus_addr_i,
	input  wire logic [7:0]              bus_wdata_i,
	input  wire logic                    bus_wr_i,
	input  wire logic                    bus_rd_i,
	output logic      [7:0]              bus_rdata_o,
	input  wire logic                    sp_push_i,
	input  wire logic                    sp_pop_i,
	output logic      [7:0]              stack_top_pointer_o,
	input  wire logic                    data_pointer_pair_wr_i,
	input  wire logic [15:0]             data_pointer_pair_wdata_i,
	input  wire logic                    data_pointer_pair_inc_i,
	output logic      [15:0]             data_pointer_pair_o,
	output logic      [7:0]              tx_data_o,
	output logic                         tx_start_o,
	input  wire logic                    rx_load_i,
	input  wire logic [7:0]              rx_data_i,
	input  wire logic [2:0]              tmr_inc_i,
	input  wire sfrb_pkg::sfrb_t2_mode_t t2_mode_i,
	input  wire logic                    timer_two_trigger_input_i,
	output logic      [15:0]             tmr0_count_o,
	output logic      [15:0]             tmr1_count_o,
	output logic      [15:0]             tmr2_count_o,
	output logic      [2:0]              tmr_ovf_o,
	input  wire logic                    md_wr_i,
	input  wire logic [7:0]              md_result_i,
	output logic      [7:0]              aux_mul_o,
	output logic      [7:0]              accumulator_register_o
);

	// ==========================================
	// Reset release
	logic rst_meta_r;
	logic rst_n;

	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rst_meta_r <= 1'b0;
			rst_n      <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_n      <= rst_meta_r;
		end
	end

	// ==========================================
	// Address decode
	wire wr_sp_w    = bus_wr_i && (bus_addr_i == `SFRB_ADDR_STACK_TOP);
	wire wr_dpl_w   = bus_wr_i && (bus_addr_i == `SFRB_ADDR_DATA_POINTER_PAIR_LOW);
	wire wr_dph_w   = bus_wr_i && (bus_addr_i == `SFRB_ADDR_DATA_POINTER_PAIR_HIGH);
	wire wr_serial_holding_buffer_w  = bus_wr_i && (bus_addr_i == `SFRB_ADDR_SERIAL_BUF);
	wire wr_ext_w   = bus_wr_i && (bus_addr_i == `SFRB_ADDR_EXT_CTRL);
	wire wr_capl_w  = bus_wr_i && (bus_addr_i == `SFRB_ADDR_CAPT_LOW);
	wire wr_caph_w  = bus_wr_i && (bus_addr_i == `SFRB_ADDR_CAPT_HIGH);
	wire wr_acc_w   = bus_wr_i && (bus_addr_i == `SFRB_ADDR_ACCUM);
	wire wr_b_w     = bus_wr_i && (bus_addr_i == `SFRB_ADDR_AUX_MUL);
	wire wr_t0l_w   = bus_wr_i && (bus_addr_i == `SFRB_ADDR_T0_LOW);
	wire wr_t0h_w   = bus_wr_i && (bus_addr_i == `SFRB_ADDR_T0_HIGH);
	wire wr_t1l_w   = bus_wr_i && (bus_addr_i == `SFRB_ADDR_T1_LOW);
	wire wr_t1h_w   = bus_wr_i && (bus_addr_i == `SFRB_ADDR_T1_HIGH);
	wire wr_t2l_w   = bus_wr_i && (bus_addr_i == `SFRB_ADDR_T2_LOW);
	wire wr_t2h_w   = bus_wr_i && (bus_addr_i == `SFRB_ADDR_T2_HIGH);

	// ==========================================
	// Storage
	logic [7:0]  sp_r;
	logic [7:0]  sp_nxt;
	logic [7:0]  dpl_r;
	logic [7:0]  dph_r;
	logic [15:0] data_pointer_pair_nxt;
	logic [7:0]  tx_hold_r;
	logic        tx_start_r;
	logic [7:0]  rx_hold_r;
	logic [7:0]  capl_r;
	logic [7:0]  caph_r;
	logic [15:0] cap_nxt;
	logic [7:0]  acc_r;
	logic [7:0]  b_r;
	logic [7:0]  b_nxt;
	logic [7:0]  ext_ctrl_r;
	logic        trig_prev_r;
	logic [7:0]  rdata_r;
	logic [7:0]  rdata_nxt;
	logic [7:0]  read_sel;
	logic [15:0] t0_cnt;
	logic [15:0] t1_cnt;
	logic [15:0] t2_cnt;
	logic [2:0]  ovf;

	// ==========================================
	// Stack pointer: bus write, then push, then pop
	assign sp_nxt = wr_sp_w ? bus_wdata_i :
	                sp_push_i ? sp_r + 8'h01 :
	                sp_pop_i ? sp_r - 8'h01 :
	                sp_r;

	// ==========================================
	// Data pointer: byte writes and word access share one pair
	assign data_pointer_pair_nxt = (wr_dpl_w || wr_dph_w) ?
	                  {(wr_dph_w ? bus_wdata_i : dph_r), (wr_dpl_w ? bus_wdata_i : dpl_r)} :
	                  data_pointer_pair_wr_i ? data_pointer_pair_wdata_i :
	                  data_pointer_pair_inc_i ? {dph_r, dpl_r} + 16'h0001 :
	                  {dph_r, dpl_r};

	// ==========================================
	// Timer 2 trigger transition; falling edge unless any edge is enabled
	wire any_edge_w = ext_ctrl_r[`SFRB_EXT_ANY_EDGE_BIT];
	wire trig_edge_w = any_edge_w ? (trig_prev_r ^ timer_two_trigger_input_i) :
	                   (trig_prev_r && !timer_two_trigger_input_i);
	wire capture_w = (t2_mode_i == sfrb_pkg::SFRB_T2_CAPTURE) && trig_edge_w;
	wire reload_en_w = (t2_mode_i == sfrb_pkg::SFRB_T2_RELOAD);

	// Hardware capture wins over a software write in the same cycle
	assign cap_nxt = capture_w ? t2_cnt :
	                 {(wr_caph_w ? bus_wdata_i : caph_r), (wr_capl_w ? bus_wdata_i : capl_r)};

	// Multiply/divide result wins; otherwise plain scratch storage
	assign b_nxt = md_wr_i ? md_result_i :
	               wr_b_w ? bus_wdata_i :
	               b_r;

	// ==========================================
	// Read selection; anything not listed reads zero
	assign read_sel =
		(bus_addr_i == `SFRB_ADDR_STACK_TOP)  ? sp_r :
		(bus_addr_i == `SFRB_ADDR_DATA_POINTER_PAIR_LOW)   ? dpl_r :
		(bus_addr_i == `SFRB_ADDR_DATA_POINTER_PAIR_HIGH)  ? dph_r :
		(bus_addr_i == `SFRB_ADDR_SERIAL_BUF) ? rx_hold_r :
		(bus_addr_i == `SFRB_ADDR_EXT_CTRL)   ? ext_ctrl_r :
		(bus_addr_i == `SFRB_ADDR_CAPT_LOW)   ? capl_r :
		(bus_addr_i == `SFRB_ADDR_CAPT_HIGH)  ? caph_r :
		(bus_addr_i == `SFRB_ADDR_ACCUM)      ? acc_r :
		(bus_addr_i == `SFRB_ADDR_AUX_MUL)    ? b_r :
		(bus_addr_i == `SFRB_ADDR_T0_LOW)     ? t0_cnt[7:0] :
		(bus_addr_i == `SFRB_ADDR_T0_HIGH)    ? t0_cnt[15:8] :
		(bus_addr_i == `SFRB_ADDR_T1_LOW)     ? t1_cnt[7:0] :
		(bus_addr_i == `SFRB_ADDR_T1_HIGH)    ? t1_cnt[15:8] :
		(bus_addr_i == `SFRB_ADDR_T2_LOW)     ? t2_cnt[7:0] :
		(bus_addr_i == `SFRB_ADDR_T2_HIGH)    ? t2_cnt[15:8] :
		8'h00;

	// Data only in the cycle after the read strobe
	assign rdata_nxt = bus_rd_i ? read_sel : 8'h00;

	// ==========================================
	// Register updates
	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sp_r        <= `SFRB_RST_STACK_TOP;
			dpl_r       <= `SFRB_RST_BYTE;
			dph_r       <= `SFRB_RST_BYTE;
			tx_hold_r   <= `SFRB_RST_BYTE;
			tx_start_r  <= 1'b0;
			rx_hold_r   <= `SFRB_RST_BYTE;
			capl_r      <= `SFRB_RST_BYTE;
			caph_r      <= `SFRB_RST_BYTE;
			acc_r       <= `SFRB_RST_BYTE;
			b_r         <= `SFRB_RST_BYTE;
			ext_ctrl_r  <= `SFRB_RST_EXT_CTRL;
			trig_prev_r <= 1'b1;
			rdata_r     <= `SFRB_RST_BYTE;
		end
		else
		begin
			sp_r        <= sp_nxt;
			{dph_r, dpl_r} <= data_pointer_pair_nxt;
			// Transmit side only; receive side is a separate register
			tx_hold_r   <= wr_serial_holding_buffer_w ? bus_wdata_i : tx_hold_r;
			tx_start_r  <= wr_serial_holding_buffer_w;
			rx_hold_r   <= rx_load_i ? rx_data_i : rx_hold_r;
			{caph_r, capl_r} <= cap_nxt;
			acc_r       <= wr_acc_w ? bus_wdata_i : acc_r;
			b_r         <= b_nxt;
			// Only the defined bit stores; the rest stays zero
			ext_ctrl_r  <= wr_ext_w ?
			               {7'h00, bus_wdata_i[`SFRB_EXT_ANY_EDGE_BIT]} : ext_ctrl_r;
			trig_prev_r <= timer_two_trigger_input_i;
			rdata_r     <= rdata_nxt;
		end
	end

	// ==========================================
	// Timer count pairs
	wire sfrb_pkg::sfrb_cnt_ctl_t t0_ctl = '{wr_lo: wr_t0l_w, wr_hi: wr_t0h_w, inc: tmr_inc_i[0]};
	wire sfrb_pkg::sfrb_cnt_ctl_t t1_ctl = '{wr_lo: wr_t1l_w, wr_hi: wr_t1h_w, inc: tmr_inc_i[1]};
	wire sfrb_pkg::sfrb_cnt_ctl_t t2_ctl = '{wr_lo: wr_t2l_w, wr_hi: wr_t2h_w, inc: tmr_inc_i[2]};

	sfrb_count_pair u_tmr0
	(
		.sys_clk_i    (sys_clk_i),
		.rst_n_i      (rst_n),
		.ctl_i        (t0_ctl),
		.wdata_i      (bus_wdata_i),
		.reload_en_i  (1'b0),
		.reload_val_i (16'h0000),
		.count_o      (t0_cnt),
		.ovf_o        (ovf[0])
	);

	sfrb_count_pair u_tmr1
	(
		.sys_clk_i    (sys_clk_i),
		.rst_n_i      (rst_n),
		.ctl_i        (t1_ctl),
		.wdata_i      (bus_wdata_i),
		.reload_en_i  (1'b0),
		.reload_val_i (16'h0000),
		.count_o      (t1_cnt),
		.ovf_o        (ovf[1])
	);

	sfrb_count_pair u_tmr2
	(
		.sys_clk_i    (sys_clk_i),
		.rst_n_i      (rst_n),
		.ctl_i        (t2_ctl),
		.wdata_i      (bus_wdata_i),
		.reload_en_i  (reload_en_w),
		.reload_val_i ({caph_r, capl_r}),
		.count_o      (t2_cnt),
		.ovf_o        (ovf[2])
	);

	// ==========================================
	// Outputs
	assign bus_rdata_o            = rdata_r;
	assign stack_top_pointer_o    = sp_r;
	assign data_pointer_pair_o    = {dph_r, dpl_r};
	assign tx_data_o              = tx_hold_r;
	assign tx_start_o             = tx_start_r;
	assign tmr0_count_o           = t0_cnt;
	assign tmr1_count_o           = t1_cnt;
	assign tmr2_count_o           = t2_cnt;
	assign tmr_ovf_o              = ovf;
	assign aux_mul_o              = b_r;
	assign accumulator_register_o = acc_r;

	// ==========================================
	// Checks
	a_sp_reset_value: assert property (
		@(posedge sys_clk_i) $rose(rst_n) |-> (stack_top_pointer_o == 8'h07))
		else $error("stack pointer not 07h after reset");

	a_sp_push_first: assert property (
		@(posedge sys_clk_i) disable iff (!rst_n)
		(sp_push_i && !wr_sp_w) |=> (stack_top_pointer_o == $past(stack_top_pointer_o) + 8'h01))
		else $error("push did not pre-increment stack pointer");

	a_data_pointer_pair_word_write: assert property (
		@(posedge sys_clk_i) disable iff (!rst_n)
		(data_pointer_pair_wr_i && !wr_dpl_w && !wr_dph_w) |=> (data_pointer_pair_o == $past(data_pointer_pair_wdata_i)))
		else $error("word write to data pointer lost");

	a_data_pointer_pair_byte_indep: assert property (
		@(posedge sys_clk_i) disable iff (!rst_n)
		(wr_dpl_w && !wr_dph_w) |=> (data_pointer_pair_o[15:8] == $past(data_pointer_pair_o[15:8]))
		&& (data_pointer_pair_o[7:0] == $past(bus_wdata_i)))
		else $error("low byte write disturbed high byte");

	a_tx_start_once: assert property (
		@(posedge sys_clk_i) disable iff (!rst_n)
		(wr_serial_holding_buffer_w ##1 !wr_serial_holding_buffer_w) |-> (tx_start_o && tx_data_o == $past(bus_wdata_i)) ##1 !tx_start_o)
		else $error("serial buffer write did not start one transmission");

	a_serial_holding_buffer_reads_rx: assert property (
		@(posedge sys_clk_i) disable iff (!rst_n)
		(bus_rd_i && bus_addr_i == `SFRB_ADDR_SERIAL_BUF) |=> (bus_rdata_o == $past(rx_hold_r)))
		else $error("serial buffer read did not return receive data");

	a_t2_capture_copy: assert property (
		@(posedge sys_clk_i) disable iff (!rst_n)
		capture_w |=> ({caph_r, capl_r} == $past(tmr2_count_o)))
		else $error("capture did not copy timer 2 count");

	a_t2_reload_value: assert property (
		@(posedge sys_clk_i) disable iff (!rst_n)
		(reload_en_w && tmr_inc_i[2] && tmr2_count_o == 16'hffff && !wr_t2l_w && !wr_t2h_w)
		|=> (tmr2_count_o == $past({caph_r, capl_r})) && tmr_ovf_o[2])
		else $error("timer 2 did not reload from capture pair");

	a_t0_counts_up: assert property (
		@(posedge sys_clk_i) disable iff (!rst_n)
		(tmr_inc_i[0] && !wr_t0l_w && !wr_t0h_w) |=> (tmr0_count_o == $past(tmr0_count_o) + 16'h0001))
		else $error("timer 0 did not count as a 16-bit pair");

	a_md_result_load: assert property (
		@(posedge sys_clk_i) disable iff (!rst_n)
		md_wr_i |=> (aux_mul_o == $past(md_result_i)))
		else $error("multiply/divide result not held");

	a_unmapped_zero: assert property (
		@(posedge sys_clk_i) disable iff (!rst_n)
		(bus_rd_i && bus_addr_i == 8'hc2) |=> (bus_rdata_o == 8'h00) ##1 (bus_rdata_o == 8'h00 || $past(bus_rd_i)))
		else $error("unimplemented location read non-zero");

	a_sp_pop_down: assert property (
		@(posedge sys_clk_i) disable iff (!rst_n)
		(sp_pop_i && !sp_push_i && !wr_sp_w)
		|=> (stack_top_pointer_o == $past(stack_top_pointer_o) - 8'h01))
		else $error("pop did not decrement stack pointer");

	a_data_pointer_pair_inc_carry: assert property (
		@(posedge sys_clk_i) disable iff (!rst_n)
		(data_pointer_pair_inc_i && !data_pointer_pair_wr_i && !wr_dpl_w && !wr_dph_w)
		|=> (data_pointer_pair_o == $past(data_pointer_pair_o) + 16'h0001))
		else $error("data pointer increment did not carry as one word");

	a_tx_hold_kept: assert property (
		@(posedge sys_clk_i) disable iff (!rst_n)
		!wr_serial_holding_buffer_w |=> (tx_data_o == $past(tx_data_o)))
		else $error("transmit holding register changed without a write");

	a_trig_fall_only: assert property (
		@(posedge sys_clk_i) disable iff (!rst_n)
		(!any_edge_w && !(trig_prev_r && !timer_two_trigger_input_i)
		 && !wr_caph_w && !wr_capl_w) |=> $stable({caph_r, capl_r}))
		else $error("capture pair moved without a falling trigger edge");

endmodule : sfrb_bank
`default_nettype wire

/* sfrb_count_pair_note_unused.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* sfrb_core_model.sv */
`timescale 1ns/1ps
`default_nettype none

module sfrb_core_model
(
	input  wire logic       sys_clk_i,
	input  wire logic       push_req_i,
	input  wire logic       pop_req_i,
	input  wire logic [7:0] stack_top_pointer_i,
	output logic            sp_push_o,
	output logic            sp_pop_o,
	output logic      [7:0] store_addr_o
);
	logic       push_r = 1'b0;
	logic       pop_r  = 1'b0;
	logic       dly_r  = 1'b0;
	logic [7:0] addr_r = 8'h00;

	assign sp_push_o    = push_r;
	assign sp_pop_o     = pop_r;
	assign store_addr_o = addr_r;

	// ==========================================
	// Execution side of push and pop
	always @(posedge sys_clk_i)
	begin
		push_r <= push_req_i;
		pop_r  <= pop_req_i;
		dly_r  <= push_r;
		// Byte goes where the pointer already moved to
		if (dly_r)
			addr_r <= stack_top_pointer_i;
	end
endmodule : sfrb_core_model
`default_nettype wire

/* sfrb_bank_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sfrb_consts.svh"

module sfrb_bank_bench;
	logic        clk   = 1'b0;
	logic        nrst  = 1'b0;
	logic [7:0]  addr  = 8'h00;
	logic [7:0]  wdata = 8'h00;
	logic [7:0]  rxd   = 8'h00;
	logic [7:0]  mdr   = 8'h00;
	logic        wr    = 1'b0;
	logic        rd    = 1'b0;
	logic        pushq = 1'b0;
	logic        popq  = 1'b0;
	logic        dwr   = 1'b0;
	logic        dinc  = 1'b0;
	logic        rxl   = 1'b0;
	logic        mdw   = 1'b0;
	logic        trig  = 1'b1;
	logic [15:0] dw    = 16'h0000;
	logic [2:0]  inc   = 3'b000;
	logic [7:0]  rdata, sp, txd, aux, acc, sa, r, v;
	logic        push, pop, txs;
	logic [15:0] dp, w;
	logic [15:0] cnt [3];
	logic [2:0]  ovf;
	logic [7:0]  tl [3] = '{8'h8a, 8'h8b, 8'hcc};
	logic [7:0]  th [3] = '{8'h8c, 8'h8d, 8'hcd};
	sfrb_pkg::sfrb_t2_mode_t mode = sfrb_pkg::SFRB_T2_TIMER;
	int          err_count   = 0;
	int          checks_done = 0;
	int          cyc         = 0;

	always #4 clk = ~clk;

	sfrb_bank dut (.sys_clk_i(clk), .nrst_i(nrst), .bus_addr_i(addr), .bus_wdata_i(wdata),
		.bus_wr_i(wr), .bus_rd_i(rd), .bus_rdata_o(rdata), .sp_push_i(push), .sp_pop_i(pop),
		.stack_top_pointer_o(sp), .data_pointer_pair_wr_i(dwr), .data_pointer_pair_wdata_i(dw), .data_pointer_pair_inc_i(dinc),
		.data_pointer_pair_o(dp), .tx_data_o(txd), .tx_start_o(txs), .rx_load_i(rxl),
		.rx_data_i(rxd), .tmr_inc_i(inc), .t2_mode_i(mode), .timer_two_trigger_input_i(trig),
		.tmr0_count_o(cnt[0]), .tmr1_count_o(cnt[1]), .tmr2_count_o(cnt[2]), .tmr_ovf_o(ovf),
		.md_wr_i(mdw), .md_result_i(mdr), .aux_mul_o(aux), .accumulator_register_o(acc));

	sfrb_core_model core (.sys_clk_i(clk), .push_req_i(pushq), .pop_req_i(popq),
		.stack_top_pointer_i(sp), .sp_push_o(push), .sp_pop_o(pop), .store_addr_o(sa));

	// ==========================================
	// Shared tasks
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic bwr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : bwr

	task automatic brd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : brd

	// One-cycle core strobe; returns just after the edge that takes it
	task automatic pulse(input int k);
		@(posedge clk);
		case (k)
			0: pushq <= 1'b1;
			1: popq  <= 1'b1;
			2: dinc  <= 1'b1;
			3: rxl   <= 1'b1;
			4: mdw   <= 1'b1;
			8: dwr   <= 1'b1;
			default: inc[k-5] <= 1'b1;
		endcase
		@(posedge clk);
		{pushq, popq, dinc, rxl, mdw, dwr} <= 6'h00;
		inc <= 3'b000;
		#1;
	endtask : pulse

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : complete_run

	// Whole sequence needs well under a thousand cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			err_count++;
			complete_run();
		end
	end

	// ==========================================
	// Tests
	initial
	begin
		void'($urandom(12));
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		check("sp reset", sp, 8'h07);
		brd(`SFRB_ADDR_STACK_TOP, r);
		check("sp read", r, 8'h07);
		brd(`SFRB_ADDR_EXT_CTRL, r);
		check("ext ctrl", r, 8'h00);
		// Software keeps ones out of unimplemented bits
		bwr(8'hc2, 8'h00);
		brd(8'hc2, r);
		check("unmapped", r, 8'h00);
		$display("test reset done");

		pulse(0);
		repeat (2) @(posedge clk);
		#1;
		check("sp push", sp, 8'h08);
		check("first slot", sa, 8'h08);
		v = 8'($urandom);
		bwr(`SFRB_ADDR_STACK_TOP, v);
		check("sp out", sp, v);
		pulse(0);
		repeat (2) @(posedge clk);
		#1;
		check("push slot", sa, 8'(v + 8'h01));
		pulse(1);
		repeat (2) @(posedge clk);
		#1;
		check("sp pop", sp, v);
		$display("test stack done");

		w = 16'($urandom);
		bwr(`SFRB_ADDR_DATA_POINTER_PAIR_LOW, w[7:0]);
		bwr(`SFRB_ADDR_DATA_POINTER_PAIR_HIGH, w[15:8]);
		check("data_pointer_pair pair", dp, w);
		@(posedge clk);
		w = {8'($urandom), 8'hff};
		dw <= w;
		pulse(8);
		check("data_pointer_pair word", dp, w);
		pulse(2);
		w = w + 16'h0001;
		check("data_pointer_pair carry", dp, w);
		brd(`SFRB_ADDR_DATA_POINTER_PAIR_HIGH, r);
		check("data_pointer_pair high", r, w[15:8]);
		bwr(`SFRB_ADDR_DATA_POINTER_PAIR_HIGH, 8'h5a);
		check("data_pointer_pair byte", dp, {8'h5a, w[7:0]});
		$display("test data pointer done");

		v = 8'($urandom);
		bwr(`SFRB_ADDR_SERIAL_BUF, v);
		check("tx start", txs, 1'b1);
		check("tx data", txd, v);
		@(posedge clk);
		#1;
		check("tx start end", txs, 1'b0);
		rxd <= ~v;
		pulse(3);
		brd(`SFRB_ADDR_SERIAL_BUF, r);
		check("rx read", r, rxd);
		check("tx kept", txd, v);
		$display("test serial done");

		for (int i = 0; i < 3; i++)
		begin
			w = 16'($urandom);
			bwr(tl[i], w[7:0]);
			bwr(th[i], w[15:8]);
			check("timer count", cnt[i], w);
			bwr(tl[i], 8'hff);
			bwr(th[i], 8'hff);
			pulse(5 + i);
			check("timer wrap", cnt[i], 16'h0000);
			check("overflow", ovf[i], 1'b1);
			@(posedge clk);
			#1;
			check("overflow end", ovf[i], 1'b0);
		end
		$display("test timers done");

		@(posedge clk);
		mode <= sfrb_pkg::SFRB_T2_CAPTURE;
		w = 16'($urandom);
		bwr(`SFRB_ADDR_T2_LOW, w[7:0]);
		bwr(`SFRB_ADDR_T2_HIGH, w[15:8]);
		@(posedge clk);
		trig <= 1'b0;
		brd(`SFRB_ADDR_CAPT_LOW, r);
		check("capture low", r, w[7:0]);
		brd(`SFRB_ADDR_CAPT_HIGH, r);
		check("capture high", r, w[15:8]);
		bwr(`SFRB_ADDR_EXT_CTRL, 8'h01);
		w = 16'($urandom);
		bwr(`SFRB_ADDR_T2_LOW, w[7:0]);
		bwr(`SFRB_ADDR_T2_HIGH, w[15:8]);
		@(posedge clk);
		trig <= 1'b1;
		brd(`SFRB_ADDR_CAPT_HIGH, r);
		check("rising capture", r, w[15:8]);
		bwr(`SFRB_ADDR_EXT_CTRL, 8'h00);
		$display("test capture done");

		@(posedge clk);
		mode <= sfrb_pkg::SFRB_T2_RELOAD;
		w = 16'($urandom);
		bwr(`SFRB_ADDR_CAPT_LOW, w[7:0]);
		bwr(`SFRB_ADDR_CAPT_HIGH, w[15:8]);
		bwr(`SFRB_ADDR_T2_LOW, 8'hff);
		bwr(`SFRB_ADDR_T2_HIGH, 8'hff);
		pulse(7);
		check("reload", cnt[2], w);
		$display("test reload done");

		v = 8'($urandom);
		bwr(`SFRB_ADDR_ACCUM, ~v);
		bwr(`SFRB_ADDR_AUX_MUL, v);
		brd(`SFRB_ADDR_AUX_MUL, r);
		check("aux scratch", r, v);
		brd(`SFRB_ADDR_ACCUM, r);
		check("acc read", r, 8'(~v));
		check("acc out", acc, 8'(~v));
		mdr <= ~v;
		pulse(4);
		check("md result", aux, mdr);
		$display("test aux done");
		complete_run();
	end
endmodule : sfrb_bank_bench
`default_nettype wire
